// file: hw/wpc_fifo.v
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
module wpc_fifo #(
  parameter WIDTH = 3,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready,
  output wire [AW:0] level
);

  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] cnt_ff;
  wire do_wr;
  wire do_rd;

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  assign in_ready = (cnt_ff != DEPTH[AW:0]);
  assign out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;
  assign out_data = mem_ff[rd_ptr_ff];
  assign level = cnt_ff;

  // Storage is not reset; only pointers and count carry state
  always @(posedge clk) begin
    if (do_wr) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers wrap at DEPTH, which must be a power of two
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (do_wr & ~do_rd) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (do_rd & ~do_wr) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

endmodule

// file: hw/wpc_map.vh
// Constants for the write precompensation and read clock block
`ifndef WPC_MAP_VH
`define WPC_MAP_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses on APB)
// ----------------------------------------------------------------
`define WPC_ADDR_CTRL 8'h00
`define WPC_ADDR_SWITCH 8'h04
`define WPC_ADDR_STATUS 8'h08

// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define WPC_CTRL_EN_BIT 0
`define WPC_CTRL_RST 32'h0000_0001
// Switch bank: four 4-bit load codes
`define WPC_SW_OUT_EARLY 3:0
`define WPC_SW_OUT_LATE 7:4
`define WPC_SW_IN_EARLY 11:8
`define WPC_SW_IN_LATE 15:12
// One step early/late outside, three steps inside
`define WPC_SW_RST 16'h4A68

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define WPC_ST_BUSY_BIT 0
`define WPC_ST_DENS_BIT 1
`define WPC_ST_INNER_BIT 2
`define WPC_ST_CNT_LSB 8
`define WPC_ST_LEVEL_LSB 27

// ----------------------------------------------------------------
// Counter codes
// ----------------------------------------------------------------
`define WPC_CODE_CENTER 4'h7
`define WPC_CODE_MAX 4'hE

// ----------------------------------------------------------------
// Times and cycle counts
// ----------------------------------------------------------------
`define WPC_CLK_NS 100
`define WPC_WPULSE_NS 250
`define WPC_RPULSE_NS 200
`define WPC_WPULSE_CYC ((`WPC_WPULSE_NS + `WPC_CLK_NS - 1) / `WPC_CLK_NS)
`define WPC_RPULSE_CYC ((`WPC_RPULSE_NS + `WPC_CLK_NS - 1) / `WPC_CLK_NS)

`endif

// file: hw/wpc_oneshot.v
// Retriggerable one-shot of fixed width in clock cycles
`timescale 1ns/100ps
module wpc_oneshot #(
  parameter WIDTH_CYC = 3,
  parameter CW = 4
) (
  input wire clk,
  input wire rst,
  input wire trig,
  output wire pulse
);

  reg [CW-1:0] cnt_ff;
  reg out_ff;

  // Load on trigger, run down to zero; output registered
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= {CW{1'b0}};
      out_ff <= 1'b0;
    end else begin
      if (trig) begin
        cnt_ff <= WIDTH_CYC[CW-1:0] - 1'b1;
        out_ff <= 1'b1;
      end else if (cnt_ff != {CW{1'b0}}) begin
        cnt_ff <= cnt_ff - 1'b1;
      end else begin
        out_ff <= 1'b0;
      end
    end
  end

  assign pulse = out_ff;

endmodule

// file: hw/wpc_top.v
// Write precompensation, read pulse shaping and read clock divider
//
// Behaviour
// - Early, late and inner-track flags pick one of four switch codes.
// - Loading the counter starts its countdown at once.
// - Neither early nor late loads centre code 7, zero shift.
// - Codes 6..0 are later, codes 8..14 earlier, around centre.
// - Each counter step is one delay step of the write pulse.
// - Counter counts down after loading until it carries.
// - Carry is delayed one clock, then fires a 300 ns (3-clock) pulse.
// - That fixed-width pulse is the write data to the drive.
// - After carry the counter halts until the next write pulse.
// - Read pulses pass a one-shot to raw read and phase outputs.
// - Oscillator divided by 2 or 4 per density select.
`timescale 1ns/100ps
`include "wpc_map.vh"
module wpc_top #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire CLOCK,
  input wire RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire WR_PULSE,
  input wire WR_EARLY,
  input wire WR_LATE,
  input wire INNER_TRACK,
  input wire DENSITY_SELECT,
  output wire WR_READY,
  output wire WDATA_OUT,
  input wire READ_IN,
  output wire RAW_READ_OUT,
  output wire PHASE_OUT,
  input wire OSC_IN,
  output wire READ_CLOCK
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg [31:0] ctrl_ff;
  reg [15:0] sw_ff;
  reg [31:0] prdata_ff;
  reg [2:0] wp_sync_ff;
  reg [1:0] early_sync_ff;
  reg [1:0] late_sync_ff;
  reg [1:0] inner_sync_ff;
  reg [1:0] dens_sync_ff;
  reg [2:0] rd_sync_ff;
  reg [2:0] osc_sync_ff;
  reg [3:0] cnt_ff;
  reg run_ff;
  reg carry_ff;
  reg [1:0] div_ff;
  reg rclk_ff;
  reg [15:0] wcount_ff;
  reg [31:0] nxt_prdata;
  reg nxt_map;
  wire wp_rise;
  wire rd_rise;
  wire osc_rise;
  wire [2:0] fifo_in;
  wire [2:0] fifo_out;
  wire fifo_valid;
  wire fifo_pop;
  wire [FIFO_AW:0] fifo_level;
  wire carry;
  wire wr_acc;
  wire rd_setup;
  wire [3:0] load_code;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // One-of-four pick from the switch bank
  function [3:0] pick_code;
    input early;
    input late;
    input inner;
    input [15:0] bank;
    begin
      case ({inner, early, late})
        3'b010: pick_code = bank[`WPC_SW_OUT_EARLY];
        3'b001: pick_code = bank[`WPC_SW_OUT_LATE];
        3'b110: pick_code = bank[`WPC_SW_IN_EARLY];
        3'b101: pick_code = bank[`WPC_SW_IN_LATE];
        default: pick_code = `WPC_CODE_CENTER;
      endcase
    end
  endfunction

  // Countdown length: lower code means later pulse
  function [3:0] delay_of;
    input [3:0] code;
    begin
      if (code > `WPC_CODE_MAX) begin
        delay_of = 4'h0;
      end else begin
        delay_of = `WPC_CODE_MAX - code;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two stages before use; third stage only for edge detection
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      wp_sync_ff <= 3'h0;
      early_sync_ff <= 2'h0;
      late_sync_ff <= 2'h0;
      inner_sync_ff <= 2'h0;
      dens_sync_ff <= 2'h0;
      rd_sync_ff <= 3'h0;
      osc_sync_ff <= 3'h0;
    end else begin
      wp_sync_ff <= {wp_sync_ff[1:0], WR_PULSE};
      early_sync_ff <= {early_sync_ff[0], WR_EARLY};
      late_sync_ff <= {late_sync_ff[0], WR_LATE};
      inner_sync_ff <= {inner_sync_ff[0], INNER_TRACK};
      dens_sync_ff <= {dens_sync_ff[0], DENSITY_SELECT};
      rd_sync_ff <= {rd_sync_ff[1:0], READ_IN};
      osc_sync_ff <= {osc_sync_ff[1:0], OSC_IN};
    end
  end

  assign wp_rise = wp_sync_ff[1] & ~wp_sync_ff[2];
  assign rd_rise = rd_sync_ff[1] & ~rd_sync_ff[2];
  assign osc_rise = osc_sync_ff[1] & ~osc_sync_ff[2];

  // ----------------------------------------------------------------
  // Write pulse capture
  // ----------------------------------------------------------------
  // Flags ride with the pulse; sampled once at its rising edge
  assign fifo_in = {inner_sync_ff[1], early_sync_ff[1], late_sync_ff[1]};

  // Queue absorbs pulses arriving while a countdown runs
  wpc_fifo #(
    .WIDTH(3),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(CLOCK),
    .rst(RST),
    .in_data(fifo_in),
    .in_valid(wp_rise & ctrl_ff[`WPC_CTRL_EN_BIT]),
    .in_ready(WR_READY),
    .out_data(fifo_out),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .level(fifo_level)
  );

  // ----------------------------------------------------------------
  // Precompensation counter
  // ----------------------------------------------------------------
  // Pop only while idle, so a held code is never overwritten
  assign fifo_pop = fifo_valid & ~run_ff;
  assign load_code = pick_code(fifo_out[1], fifo_out[0], fifo_out[2], sw_ff);
  assign carry = run_ff & (cnt_ff == 4'h0);

  // One step per clock; load starts counting, carry halts it
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      cnt_ff <= 4'h0;
      run_ff <= 1'b0;
      carry_ff <= 1'b0;
      wcount_ff <= 16'h0000;
    end else begin
      carry_ff <= carry;
      if (fifo_pop) begin
        cnt_ff <= delay_of(load_code);
        run_ff <= 1'b1;
      end else if (carry) begin
        run_ff <= 1'b0;
      end else if (run_ff) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
      if (carry) begin
        wcount_ff <= wcount_ff + 1'b1;
      end
    end
  end

  // Fixed-width write data toward the drive
  wpc_oneshot #(
    .WIDTH_CYC(`WPC_WPULSE_CYC),
    .CW(4)
  ) u_wshot (
    .clk(CLOCK),
    .rst(RST),
    .trig(carry_ff),
    .pulse(WDATA_OUT)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Same conditioned pulse feeds both consumers
  wpc_oneshot #(
    .WIDTH_CYC(`WPC_RPULSE_CYC),
    .CW(4)
  ) u_rshot (
    .clk(CLOCK),
    .rst(RST),
    .trig(rd_rise),
    .pulse(RAW_READ_OUT)
  );

  assign PHASE_OUT = RAW_READ_OUT;

  // Divide oscillator edges; density picks /2 or /4
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      div_ff <= 2'h0;
      rclk_ff <= 1'b0;
    end else begin
      if (osc_rise) begin
        div_ff <= div_ff + 1'b1;
      end
      rclk_ff <= dens_sync_ff[1] ? div_ff[0] : div_ff[1];
    end
  end

  assign READ_CLOCK = rclk_ff;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Zero wait states; read data latched in setup for a flop output
  assign PREADY = 1'b1;
  assign wr_acc = PSEL & PENABLE & PWRITE;
  assign rd_setup = PSEL & ~PENABLE;

  // Address decode and read mux
  always @* begin
    nxt_prdata = 32'h0000_0000;
    nxt_map = 1'b1;
    case (PADDR)
      `WPC_ADDR_CTRL: nxt_prdata = ctrl_ff;
      `WPC_ADDR_SWITCH: nxt_prdata = {16'h0000, sw_ff};
      `WPC_ADDR_STATUS: begin
        nxt_prdata[`WPC_ST_BUSY_BIT] = run_ff | fifo_valid;
        nxt_prdata[`WPC_ST_DENS_BIT] = dens_sync_ff[1];
        nxt_prdata[`WPC_ST_INNER_BIT] = inner_sync_ff[1];
        nxt_prdata[`WPC_ST_CNT_LSB +: 16] = wcount_ff;
        nxt_prdata[`WPC_ST_LEVEL_LSB +: FIFO_AW+1] = fifo_level; // Top bits; deeper queues need a new layout
      end
      default: nxt_map = 1'b0;
    endcase
  end

  // Error only on an unmapped access phase
  assign PSLVERR = PSEL & PENABLE & ~nxt_map;

  // Register writes and read capture
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctrl_ff <= `WPC_CTRL_RST;
      sw_ff <= `WPC_SW_RST;
      prdata_ff <= 32'h0000_0000;
    end else begin
      if (rd_setup) begin
        prdata_ff <= nxt_prdata;
      end
      if (wr_acc && PADDR == `WPC_ADDR_CTRL) begin
        ctrl_ff <= {31'h0000_0000, PWDATA[`WPC_CTRL_EN_BIT]};
      end
      if (wr_acc && PADDR == `WPC_ADDR_SWITCH) begin
        sw_ff <= PWDATA[15:0];
      end
    end
  end

  assign PRDATA = prdata_ff;

endmodule

// file: verification/test_wpc_top.sv
// Self-checking bench of the write precompensation block
`timescale 1ns/100ps
`include "wpc_map.vh"
module test_wpc_top;
  logic CLOCK, RST, PSEL, PENABLE, PWRITE, WR_PULSE, WR_EARLY, WR_LATE, INNER_TRACK, DENSITY_SELECT, OSC_IN;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, rd;
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR, WR_READY, WDATA_OUT, READ_IN, RAW_READ_OUT, PHASE_OUT, READ_CLOCK;
  logic err, rc_q, raw_q, full_seen;
  int error_cnt, num_checks, base, lat, tog, raw_n, i;
  typedef struct {logic [15:0] sw; logic [2:0] f; int off;} wpc_row_t;
  // Flags {early, late, inner}; off is the expected shift in clocks
  wpc_row_t rows[9] = '{'{16'h4A68, 3'h0, 0}, '{16'h4A68, 3'h4, -1}, '{16'h4A68, 3'h2, 1},
    '{16'h4A68, 3'h5, -3}, '{16'h4A68, 3'h3, 3}, '{16'h4A68, 3'h7, 0}, '{16'h000E, 3'h4, -7},
    '{16'h000E, 3'h2, 7}, '{16'h000E, 3'h1, 0}};
  wpc_top wpc_top_i (.*);
  wpc_drive_model wpc_drive_model_i (.clk(CLOCK), .wdata(WDATA_OUT), .rdata(READ_IN));
  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end
  // Edge counters watched by the scenarios
  always @(posedge CLOCK) begin
    if (READ_CLOCK !== rc_q) tog++;
    if (RAW_READ_OUT === 1'b1 && raw_q !== 1'b1) raw_n++;
    if (WR_READY === 1'b0) full_seen = 1'b1;
    rc_q <= READ_CLOCK;
    raw_q <= RAW_READ_OUT;
  end
  // --------
  // Tasks
  // --------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      num_checks++;
      if (seen !== exp) begin
        error_cnt++;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  task tmo;
    begin
      error_cnt++;
      finish_test;
    end
  endtask
  // One APB transfer, then one idle cycle so calls never collide
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
        @(posedge CLOCK);
        n++;
      end while (PREADY !== 1'b1 && n < 20);
      if (PREADY !== 1'b1) tmo;
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLOCK);
    end
  endtask
  // Flags f lead the pulse; g replaces them while the count runs
  task wr_pulse(input logic [2:0] f, input logic [2:0] g, output int n);
    begin
      {WR_EARLY, WR_LATE, INNER_TRACK} <= f;
      @(posedge CLOCK);
      WR_PULSE <= 1'b1;
      n = 0;
      @(posedge CLOCK);
      while (WDATA_OUT !== 1'b1 && n < 60) begin
        if (n == 2) WR_PULSE <= 1'b0;
        if (n == 3) {WR_EARLY, WR_LATE, INNER_TRACK} <= g;
        @(posedge CLOCK);
        n++;
      end
      if (n >= 60) tmo;
      repeat (4) @(posedge CLOCK);
    end
  endtask
  task do_reset(input logic d);
    begin
      RST <= 1'b1;
      DENSITY_SELECT <= d;
      repeat (12) @(posedge CLOCK);
      RST <= 1'b0;
      @(posedge CLOCK);
    end
  endtask
  // --------
  // Main sequence
  // --------
  initial begin
    {PSEL, PENABLE, PWRITE, WR_PULSE, WR_EARLY, WR_LATE, INNER_TRACK, OSC_IN} = 8'h00;
    {RST, DENSITY_SELECT, rc_q, raw_q} = 4'hC;
    PADDR = 8'h00;
    PWDATA = 32'h0000_0000;
    {error_cnt, num_checks, tog, raw_n} = 0;
    // Read clock ratio per density, with a reset between
    for (int d = 0; d < 2; d++) begin
      do_reset(d[0]);
      tog = 0;
      repeat (16) begin
        OSC_IN <= 1'b1;
        repeat (4) @(posedge CLOCK);
        OSC_IN <= 1'b0;
        repeat (4) @(posedge CLOCK);
      end
      check(tog, d ? 16 : 8);
    end
    apb(1'b0, `WPC_ADDR_CTRL, 32'h0);
    check(rd, `WPC_CTRL_RST);
    apb(1'b0, `WPC_ADDR_SWITCH, 32'h0);
    check(rd, {16'h0000, `WPC_SW_RST});
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    check(err, 1'b1);
    check(WR_READY, 1'b1);
    wr_pulse(3'h0, 3'h0, base);
    foreach (rows[k]) begin
      apb(1'b1, `WPC_ADDR_SWITCH, {16'h0000, rows[k].sw});
      apb(1'b0, `WPC_ADDR_SWITCH, 32'h0);
      check(rd, {16'h0000, rows[k].sw});
      wr_pulse(rows[k].f, rows[k].f, lat);
      check(lat, base + rows[k].off);
    end
    // Flags flipped mid-count must not move the pulse
    wr_pulse(3'h4, 3'h3, lat);
    check(lat, base - 7);
    // Disabled block drops pulses; enable restored for the queue test
    apb(1'b1, `WPC_ADDR_CTRL, 32'h0);
    apb(1'b0, `WPC_ADDR_CTRL, 32'h0);
    check(rd, 32'h0);
    lat = wpc_drive_model_i.wr_cnt;
    WR_PULSE <= 1'b1;
    repeat (2) @(posedge CLOCK);
    WR_PULSE <= 1'b0;
    repeat (30) @(posedge CLOCK);
    check(wpc_drive_model_i.wr_cnt, lat);
    apb(1'b1, `WPC_ADDR_CTRL, 32'h1);
    // Flux pulses reach the raw read output
    repeat (3) begin
      wpc_drive_model_i.send_read;
      repeat (8) @(posedge CLOCK);
    end
    check(raw_n, 3);
    // Slow code 0 lets the queue fill until it refuses
    full_seen = 1'b0;
    lat = wpc_drive_model_i.wr_cnt;
    {WR_EARLY, WR_LATE, INNER_TRACK} <= 3'h2;
    @(posedge CLOCK);
    repeat (30) begin
      WR_PULSE <= 1'b1;
      repeat (2) @(posedge CLOCK);
      WR_PULSE <= 1'b0;
      repeat (2) @(posedge CLOCK);
    end
    check(full_seen, 1'b1);
    i = 0;
    do begin
      apb(1'b0, `WPC_ADDR_STATUS, 32'h0);
      i++;
    end while ((rd[`WPC_ST_BUSY_BIT] !== 1'b0 || rd[31:27] !== 5'h00) && i < 300);
    // Queue never drained within the bound
    if (rd[`WPC_ST_BUSY_BIT] !== 1'b0 || rd[31:27] !== 5'h00) tmo;
    repeat (6) @(posedge CLOCK);
    check(rd[31:27], 5'h00);
    check(rd[`WPC_ST_DENS_BIT], 1'b1);
    check(rd[`WPC_ST_INNER_BIT], 1'b0);
    check(rd[`WPC_ST_CNT_LSB +: 16], wpc_drive_model_i.wr_cnt);
    i = wpc_drive_model_i.wr_cnt - lat;
    check(i > 16 && i < 30, 1'b1);
    check(WR_READY, 1'b1);
    finish_test;
  end
endmodule

// file: verification/wpc_assertions.sv
// Checker of port behaviour for the write precompensation block
`timescale 1ns/100ps
module wpc_checker (
  input wire CLOCK,
  input wire RST,
  input wire WR_PULSE,
  input wire WR_EARLY,
  input wire WR_LATE,
  input wire WDATA_OUT,
  input wire READ_IN,
  input wire RAW_READ_OUT,
  input wire PHASE_OUT,
  input wire DENSITY_SELECT,
  input wire OSC_IN,
  input wire READ_CLOCK
);
  reg [7:0] pend_ff;
  reg [2:0] osc_cnt_ff;
  reg wp_ff;
  reg wd_ff;
  reg osc_ff;
  reg rc_ff;
  wire osc_rise = OSC_IN & ~osc_ff;
  // Pulses owed to the drive; oscillator rises since last read clock edge
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pend_ff <= 8'h00;
      osc_cnt_ff <= 3'h0;
      wp_ff <= 1'b0;
      wd_ff <= 1'b0;
      osc_ff <= 1'b0;
      rc_ff <= 1'b0;
    end else begin
      pend_ff <= pend_ff + {7'h00, WR_PULSE & ~wp_ff} - {7'h00, WDATA_OUT & ~wd_ff};
      osc_cnt_ff <= (READ_CLOCK != rc_ff) ? 3'h0 : osc_cnt_ff + {2'h0, osc_rise};
      wp_ff <= WR_PULSE;
      wd_ff <= WDATA_OUT;
      osc_ff <= OSC_IN;
      rc_ff <= READ_CLOCK;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  chk_write_width: assert property ($rose(WDATA_OUT) |=> WDATA_OUT ##1 WDATA_OUT ##1 !WDATA_OUT)
    else $error("write pulse width wrong");
  chk_no_stray: assert property ($rose(WDATA_OUT) |-> pend_ff != 8'h00)
    else $error("write pulse without cause");
  chk_center_delay: assert property ($rose(WR_PULSE) && !WR_EARLY && !WR_LATE && pend_ff == 8'h00
    |-> ##[11:15] $rose(WDATA_OUT)) else $error("centre pulse late or missing");
  chk_read_divide: assert property ($changed(READ_CLOCK)
    |-> osc_cnt_ff + {2'h0, osc_rise} == (DENSITY_SELECT ? 3'h1 : 3'h2)) else $error("read clock ratio wrong");
  chk_read_start: assert property ($rose(READ_IN) |-> ##[2:4] $rose(RAW_READ_OUT))
    else $error("read pulse missing");
  chk_read_width: assert property ($rose(RAW_READ_OUT) |=> RAW_READ_OUT ##1 !RAW_READ_OUT)
    else $error("read pulse width wrong");
  chk_read_twin: assert property (RAW_READ_OUT == PHASE_OUT)
    else $error("read outputs differ");
  chk_read_cause: assert property ($rose(RAW_READ_OUT) |-> $past(READ_IN, 2) || $past(READ_IN, 3))
    else $error("read pulse without cause");
  cov_write: cover property ($rose(WDATA_OUT));
  cov_single: cover property ($changed(READ_CLOCK) && !DENSITY_SELECT);
  cov_read: cover property ($rose(PHASE_OUT));
endmodule
bind wpc_top wpc_checker wpc_checker_i (.*);

// file: verification/wpc_drive_model.sv
// Drive model: counts write pulses, sends flux pulses on read
`timescale 1ns/100ps
module wpc_drive_model (
  input wire clk,
  input wire wdata,
  output logic rdata
);
  int wr_cnt = 0;
  logic wd_q = 1'b0;
  initial rdata = 1'b0;
  // Each rising edge is one flux change written
  always @(posedge clk) begin
    if (wdata && !wd_q) wr_cnt <= wr_cnt + 1;
    wd_q <= wdata;
  end
  // Two clocks wide; the line idles low between pulses
  task send_read;
    begin
      rdata <= 1'b1;
      repeat (2) @(posedge clk);
      rdata <= 1'b0;
    end
  endtask
endmodule
